// File: undervoltage_stage_blocking.v
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "undervoltage_stage_defines.vh"

module undervoltage_stage_blocking #(
   parameter CYCLE_CLKS = `PROG_CYCLE_CLKS
) (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Avalon-MM slave
   input wire [6:0] address_in,
   input wire read_in,
   input wire write_in,
   input wire [31:0] writedata_in,
   output reg [31:0] readdata_out,
   output wire waitrequest_out,
   // Measurements and blocking matrix
   input wire [15:0] volt_a_in,
   input wire [15:0] volt_b_in,
   input wire [15:0] volt_c_in,
   input wire block_in,
   // Stage outputs
   output wire start_out,
   output wire trip_out,
   output wire blocked_out,
   output wire irq_out
);

   // ****************************************
   // Declarations
   // ****************************************
   reg [19:0] div_reg;
   reg step_reg;
   reg ack_reg;
   reg [2:0] mode_reg;
   reg [1:0] tmode_reg;
   reg [13:0] uset_reg;
   reg [13:0] blk_reg;
   reg [19:0] delay_reg;
   reg [19:0] release_reg;
   reg [23:0] vt_reg;
   reg [3:0] irq_status_reg;
   reg [3:0] irq_mask_reg;
   reg block_smp_reg;
   reg [15:0] ua_reg;
   reg [15:0] ub_reg;
   reg [15:0] uc_reg;
   reg pickup_reg;
   reg pickup_next;
   reg deen_reg;
   reg deen_next;
   reg start_reg;
   reg start_next;
   reg blocked_reg;
   reg blocked_next;
   reg trip_reg;
   reg trip_next;
   reg releasing_reg;
   reg releasing_next;
   reg [19:0] elapsed_reg;
   reg [19:0] elapsed_next;
   reg [19:0] rel_reg;
   reg [19:0] rel_next;
   reg [19:0] expected_reg;
   reg [19:0] expected_next;
   reg [20:0] remain_reg;
   reg [16:0] ratio_a_reg;
   reg [16:0] ratio_b_reg;
   reg [16:0] ratio_c_reg;
   reg [16:0] ratio_min_reg;
   reg [31:0] pickup_pri_reg;
   reg [31:0] block_pri_reg;
   reg [2:0] behaviour;
   reg [31:0] read_mux;
   wire tick;
   wire [15:0] umin_ab;
   wire [15:0] umin;
   wire [20:0] hyst_level;
   wire eff_block;
   wire [33:0] idmt_num;
   wire [13:0] idmt_den;
   wire [33:0] idmt_q;
   wire [37:0] pickup_prod;
   wire [37:0] block_prod;
   wire [37:0] pickup_pri;
   wire [37:0] block_pri;
   wire wr_strobe;
   wire [3:0] irq_events;

   // ****************************************
   // Ratio helper
   // ****************************************
   function [16:0] ratio_of;
      input [15:0] u;
      input [13:0] s;
      reg [22:0] q;
      begin
         q = 23'h0;
         if (s == 14'h0) begin
            ratio_of = `RATIO_MAX;
         end else begin
            q = ({7'h0, u} * `RATIO_MUL) / {9'h0, s};
            ratio_of = (q > {6'h0, `RATIO_MAX}) ? `RATIO_MAX : q[16:0];
         end
      end
   endfunction

   // ****************************************
   // Program cycle divider
   // ****************************************
   assign tick = (div_reg == CYCLE_CLKS[19:0] - 20'h1);

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_reg <= 20'h0;
         step_reg <= 1'b0;
      end else begin
         div_reg <= tick ? 20'h0 : div_reg + 20'h1;
         step_reg <= tick;
      end
   end

   // Inputs captured at the cycle start, evaluated one clock later
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         block_smp_reg <= 1'b0;
         ua_reg <= 16'h0;
         ub_reg <= 16'h0;
         uc_reg <= 16'h0;
      end else if (tick) begin
         block_smp_reg <= block_in;
         ua_reg <= volt_a_in;
         ub_reg <= volt_b_in;
         uc_reg <= volt_c_in;
      end
   end

   // ****************************************
   // Level evaluation
   // ****************************************
   assign umin_ab = (ua_reg < ub_reg) ? ua_reg : ub_reg;
   assign umin = (uc_reg < umin_ab) ? uc_reg : umin_ab;
   assign hyst_level = ({7'h0, uset_reg} * `HYST_PCT) / `PCT_DIV;
   assign eff_block = block_smp_reg | (mode_reg == `MODE_BLOCKED) |
                      (mode_reg == `MODE_TEST_BLOCKED);

   // Linear inverse law; full IDMT curves live in software
   assign idmt_num = {14'h0, delay_reg} * {20'h0, uset_reg};
   assign idmt_den = uset_reg - umin[13:0];
   assign idmt_q = (idmt_den == 14'h0) ? {14'h0, `TIME_MAX} : idmt_num / {20'h0, idmt_den};

   always @* begin
      expected_next = delay_reg;
      case (tmode_reg)
         `TMODE_INSTANT: begin
            expected_next = 20'h0;
         end
         `TMODE_IDMT: begin
            if (umin >= {2'h0, uset_reg} || idmt_q > {14'h0, `TIME_MAX}) begin
               expected_next = `TIME_MAX;
            end else begin
               expected_next = idmt_q[19:0];
            end
         end
         default: begin
            expected_next = delay_reg;
         end
      endcase
   end

   // ****************************************
   // Stage sequencing
   // ****************************************
   always @* begin
      pickup_next = pickup_reg;
      deen_next = deen_reg;
      start_next = start_reg;
      blocked_next = blocked_reg;
      trip_next = trip_reg;
      releasing_next = releasing_reg;
      elapsed_next = elapsed_reg;
      rel_next = rel_reg;
      if (step_reg) begin
         if (mode_reg == `MODE_OFF) begin
            pickup_next = 1'b0;
            deen_next = 1'b0;
            start_next = 1'b0;
            blocked_next = 1'b0;
            trip_next = 1'b0;
            releasing_next = 1'b0;
            elapsed_next = 20'h0;
            rel_next = 20'h0;
         end else begin
            if (!pickup_reg && umin < {2'h0, uset_reg}) begin
               pickup_next = 1'b1;
            end else if (pickup_reg && {5'h0, umin} >= hyst_level) begin
               pickup_next = 1'b0;
            end
            if (blk_reg == 14'h0) begin
               deen_next = 1'b0;
            end else if (umin < {2'h0, blk_reg}) begin
               deen_next = 1'b1;
            end else if (umin > {2'h0, uset_reg}) begin
               deen_next = 1'b0;
            end
            if (start_reg) begin
               if (eff_block || !pickup_next) begin
                  start_next = 1'b0;
                  trip_next = 1'b0;
                  releasing_next = 1'b1;
                  rel_next = 20'h0;
                  blocked_next = eff_block & pickup_next;
               end else begin
                  if (elapsed_reg != `TIME_MAX) begin
                     elapsed_next = elapsed_reg + 20'h1;
                  end
                  if (elapsed_next >= expected_next && !deen_next) begin
                     trip_next = 1'b1;
                  end
               end
            end else if (pickup_next) begin
               if (eff_block) begin
                  blocked_next = 1'b1;
               end else begin
                  start_next = 1'b1;
                  blocked_next = 1'b0;
                  releasing_next = 1'b0;
                  if (!releasing_reg) begin
                     elapsed_next = 20'h0;
                  end
                  if (elapsed_next >= expected_next && !deen_next) begin
                     trip_next = 1'b1;
                  end
               end
            end else begin
               blocked_next = 1'b0;
               if (releasing_reg) begin
                  if ({1'b0, rel_reg} + 21'h1 >= {1'b0, release_reg}) begin
                     elapsed_next = 20'h0;
                     releasing_next = 1'b0;
                  end else begin
                     rel_next = rel_reg + 20'h1;
                  end
               end
            end
         end
      end
   end

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pickup_reg <= 1'b0;
         deen_reg <= 1'b0;
         start_reg <= 1'b0;
         blocked_reg <= 1'b0;
         trip_reg <= 1'b0;
         releasing_reg <= 1'b0;
         elapsed_reg <= 20'h0;
         rel_reg <= 20'h0;
         expected_reg <= 20'h0;
         remain_reg <= 21'h0;
         ratio_a_reg <= 17'h0;
         ratio_b_reg <= 17'h0;
         ratio_c_reg <= 17'h0;
         ratio_min_reg <= 17'h0;
      end else begin
         pickup_reg <= pickup_next;
         deen_reg <= deen_next;
         start_reg <= start_next;
         blocked_reg <= blocked_next;
         trip_reg <= trip_next;
         releasing_reg <= releasing_next;
         elapsed_reg <= elapsed_next;
         rel_reg <= rel_next;
         if (step_reg) begin
            expected_reg <= expected_next;
            remain_reg <= start_next ? {1'b0, expected_next} - {1'b0, elapsed_next} :
                          {1'b0, expected_next};
            ratio_a_reg <= ratio_of(ua_reg, uset_reg);
            ratio_b_reg <= ratio_of(ub_reg, uset_reg);
            ratio_c_reg <= ratio_of(uc_reg, uset_reg);
            ratio_min_reg <= ratio_of(umin, uset_reg);
         end
      end
   end

   // ****************************************
   // Reported levels and behaviour
   // ****************************************
   assign pickup_prod = {24'h0, uset_reg} * {14'h0, vt_reg};
   assign block_prod = {24'h0, blk_reg} * {14'h0, vt_reg};
   assign pickup_pri = pickup_prod / `PRIMARY_DIV;
   assign block_pri = block_prod / `PRIMARY_DIV;

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pickup_pri_reg <= 32'h0;
         block_pri_reg <= 32'h0;
      end else begin
         pickup_pri_reg <= pickup_pri[31:0];
         block_pri_reg <= block_pri[31:0];
      end
   end

   always @* begin
      case (mode_reg)
         `MODE_ON: behaviour = block_smp_reg ? `MODE_BLOCKED : `MODE_ON;
         `MODE_TEST: behaviour = block_smp_reg ? `MODE_TEST_BLOCKED : `MODE_TEST;
         `MODE_BLOCKED: behaviour = `MODE_BLOCKED;
         `MODE_TEST_BLOCKED: behaviour = `MODE_TEST_BLOCKED;
         default: behaviour = `MODE_OFF;
      endcase
   end

   // Test modes show the trip flag but keep the trip output quiet
   assign start_out = start_reg;
   assign blocked_out = blocked_reg;
   assign trip_out = trip_reg & (mode_reg == `MODE_ON);

   // ****************************************
   // Avalon-MM slave
   // ****************************************
   // One wait state gives a registered read path
   assign waitrequest_out = (read_in | write_in) & ~ack_reg;
   assign wr_strobe = write_in & ack_reg;

   always @* begin
      case (address_in)
         `OFS_CTRL: read_mux = {26'h0, tmode_reg, 1'b0, mode_reg};
         `OFS_PICKUP: read_mux = {18'h0, uset_reg};
         `OFS_BLOCKLVL: read_mux = {18'h0, blk_reg};
         `OFS_DELAY: read_mux = {12'h0, delay_reg};
         `OFS_RELEASE: read_mux = {12'h0, release_reg};
         `OFS_VTSCALE: read_mux = {8'h0, vt_reg};
         `OFS_STATUS: read_mux = {21'h0, behaviour, 1'b0, releasing_reg, block_smp_reg,
                                  pickup_reg, deen_reg, blocked_reg, trip_reg, start_reg};
         `OFS_EXPECTED: read_mux = {12'h0, expected_reg};
         `OFS_REMAIN: read_mux = {{11{remain_reg[20]}}, remain_reg};
         `OFS_RATIO_A: read_mux = {15'h0, ratio_a_reg};
         `OFS_RATIO_B: read_mux = {15'h0, ratio_b_reg};
         `OFS_RATIO_C: read_mux = {15'h0, ratio_c_reg};
         `OFS_RATIO_MIN: read_mux = {15'h0, ratio_min_reg};
         `OFS_PICKUP_PRI: read_mux = pickup_pri_reg;
         `OFS_BLOCK_PRI: read_mux = block_pri_reg;
         `OFS_IRQ_STATUS: read_mux = {28'h0, irq_status_reg};
         `OFS_IRQ_MASK: read_mux = {28'h0, irq_mask_reg};
         default: read_mux = 32'h0;
      endcase
   end

   assign irq_events = {deen_next & ~deen_reg, blocked_next & ~blocked_reg,
                        trip_next & ~trip_reg, start_next & ~start_reg};
   assign irq_out = |(irq_status_reg & irq_mask_reg);

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_reg <= 1'b0;
         readdata_out <= 32'h0;
         mode_reg <= `RST_MODE;
         tmode_reg <= `RST_TMODE;
         uset_reg <= `RST_PICKUP;
         blk_reg <= `RST_BLOCKLVL;
         delay_reg <= `RST_DELAY;
         release_reg <= `RST_RELEASE;
         vt_reg <= `RST_VTSCALE;
         irq_status_reg <= 4'h0;
         irq_mask_reg <= 4'h0;
      end else begin
         ack_reg <= (read_in | write_in) & ~ack_reg;
         if (read_in & ~ack_reg) begin
            readdata_out <= read_mux;
         end
         // Set wins over a same-cycle clear
         irq_status_reg <= (irq_status_reg &
                           ~((wr_strobe && address_in == `OFS_IRQ_STATUS) ?
                             writedata_in[3:0] : 4'h0)) | irq_events;
         if (wr_strobe) begin
            case (address_in)
               `OFS_CTRL: begin
                  mode_reg <= (writedata_in[2:0] > `MODE_OFF) ? `MODE_OFF : writedata_in[2:0];
                  tmode_reg <= writedata_in[5:4];
               end
               `OFS_PICKUP: uset_reg <= writedata_in[13:0];
               `OFS_BLOCKLVL: blk_reg <= writedata_in[13:0];
               `OFS_DELAY: delay_reg <= writedata_in[19:0];
               `OFS_RELEASE: release_reg <= writedata_in[19:0];
               `OFS_VTSCALE: vt_reg <= writedata_in[23:0];
               `OFS_IRQ_MASK: irq_mask_reg <= writedata_in[3:0];
               default: begin
               end
            endcase
         end
      end
   end

endmodule // undervoltage_stage_blocking
`default_nettype wire

// File: undervoltage_stage_defines.vh
`ifndef UNDERVOLTAGE_STAGE_DEFINES_VH
`define UNDERVOLTAGE_STAGE_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 7'h00
`define OFS_PICKUP 7'h04
`define OFS_BLOCKLVL 7'h08
`define OFS_DELAY 7'h0C
`define OFS_RELEASE 7'h10
`define OFS_VTSCALE 7'h14
`define OFS_STATUS 7'h18
`define OFS_EXPECTED 7'h1C
`define OFS_REMAIN 7'h20
`define OFS_RATIO_A 7'h24
`define OFS_RATIO_B 7'h28
`define OFS_RATIO_C 7'h2C
`define OFS_RATIO_MIN 7'h30
`define OFS_PICKUP_PRI 7'h34
`define OFS_BLOCK_PRI 7'h38
`define OFS_IRQ_STATUS 7'h3C
`define OFS_IRQ_MASK 7'h40

// ****************************************
// Field positions and codes
// ****************************************
`define CTRL_MODE_LSB 0
`define CTRL_TMODE_LSB 4
`define MODE_ON 3'h0
`define MODE_BLOCKED 3'h1
`define MODE_TEST 3'h2
`define MODE_TEST_BLOCKED 3'h3
`define MODE_OFF 3'h4
`define TMODE_INSTANT 2'h0
`define TMODE_DT 2'h1
`define TMODE_IDMT 2'h2
`define IRQ_START 0
`define IRQ_TRIP 1
`define IRQ_BLOCKED 2
`define IRQ_DEENERGIZED 3

// ****************************************
// Reset values
// ****************************************
`define RST_MODE 3'h0
`define RST_TMODE 2'h1
`define RST_PICKUP 14'h1770
`define RST_BLOCKLVL 14'h03E8
`define RST_DELAY 20'h00014
`define RST_RELEASE 20'h00000
`define RST_VTSCALE 24'h0186A0

// ****************************************
// Timing and scaling
// ****************************************
`define CLK_FREQ_MHZ 125
`define PROG_CYCLE_US 5000
`define PROG_CYCLE_CLKS (`PROG_CYCLE_US * `CLK_FREQ_MHZ)
`define BLOCK_LEAD_MS 5
`define TIME_MAX 20'h57E40
`define RATIO_MAX 17'h1E848
`define HYST_PCT 21'h67
`define PCT_DIV 21'h64
`define RATIO_MUL 23'h64
`define PRIMARY_DIV 38'h2710

`endif

// File: uv_stage_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// Stage checker
// ****************
module uv_stage_checker #(parameter CYCLE_CLKS = 16) (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Register bus
   input wire [6:0] address_in,
   input wire read_in,
   input wire write_in,
   input wire [31:0] writedata_in,
   input wire [31:0] readdata_out,
   input wire waitrequest_out,
   // Stage link
   input wire [15:0] volt_a_in,
   input wire [15:0] volt_b_in,
   input wire [15:0] volt_c_in,
   input wire block_in,
   input wire start_out,
   input wire trip_out,
   input wire blocked_out,
   input wire irq_out
);
   // Mirror of the divider; start and blocked outputs move only one edge after a step
   reg [31:0] div_reg;
   wire step_seen = (div_reg == 32'h1);
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) div_reg <= 32'h0;
      else if (div_reg == CYCLE_CLKS - 1) div_reg <= 32'h0;
      else div_reg <= div_reg + 32'h1;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_req; (read_in || write_in) && waitrequest_out; endsequence
   sequence s_start_rise; $rose(start_out); endsequence
   sequence s_block_drop; $fell(start_out) && blocked_out; endsequence
   property p_first_wait; $rose(read_in || write_in) |-> waitrequest_out; endproperty
   property p_one_wait; s_req |=> !waitrequest_out; endproperty
   property p_excl; !(start_out && blocked_out); endproperty
   property p_start_ok; s_start_rise |-> !$past(block_in, 2); endproperty
   property p_drop; s_block_drop |-> $past(block_in, 2); endproperty
   property p_steps; ($changed(start_out) || $changed(blocked_out)) |-> step_seen; endproperty
   property p_trip; trip_out |-> start_out; endproperty
   property p_irq; $rose(irq_out) |-> (step_seen || $past(write_in)); endproperty
   property p_read_stands; !read_in |=> $stable(readdata_out); endproperty
   a_first_wait: assert property (p_first_wait) else $error("wait state missing");
   a_one_wait: assert property (p_one_wait) else $error("more than one wait state");
   a_excl: assert property (p_excl) else $error("start and blocked together");
   a_start_ok: assert property (p_start_ok) else $error("start despite block");
   a_drop: assert property (p_drop) else $error("start dropped without block");
   a_steps: assert property (p_steps) else $error("output moved off step");
   a_trip: assert property (p_trip) else $error("trip without start");
   a_irq: assert property (p_irq) else $error("irq rose without cause");
   a_read_stands: assert property (p_read_stands) else $error("read data moved");
endmodule // uv_stage_checker
bind undervoltage_stage_blocking uv_stage_checker #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
   .clk_in(clk_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
   .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
   .waitrequest_out(waitrequest_out), .volt_a_in(volt_a_in), .volt_b_in(volt_b_in),
   .volt_c_in(volt_c_in), .block_in(block_in), .start_out(start_out),
   .trip_out(trip_out), .blocked_out(blocked_out), .irq_out(irq_out));
`default_nettype wire

// File: blocking_matrix_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// Blocking matrix
// ****************
module blocking_matrix_model (
   // Clock and reset
   input wire clk_in,
   input wire rst_in,
   // Requests
   input wire block_req_in,
   input wire [15:0] va_req_in,
   input wire [15:0] vb_req_in,
   input wire [15:0] vc_req_in,
   // Stage side
   output reg block_out,
   output reg [15:0] volt_a_out,
   output reg [15:0] volt_b_out,
   output reg [15:0] volt_c_out
);
   // One register stage; senders lead the operate delay by far more
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         block_out <= 1'b0;
         volt_a_out <= 16'h2710;
         volt_b_out <= 16'h2710;
         volt_c_out <= 16'h2710;
      end else begin
         block_out <= block_req_in;
         volt_a_out <= va_req_in;
         volt_b_out <= vb_req_in;
         volt_c_out <= vc_req_in;
      end
   end
endmodule // blocking_matrix_model
`default_nettype wire

// File: undervoltage_stage_blocking_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "undervoltage_stage_defines.vh"
// ****************
// Testbench
// ****************
module undervoltage_stage_blocking_tb;
   localparam integer CYC = 16;
   reg clk_in = 1'b0;
   reg rst_in = 1'b1;
   reg [6:0] address_in = 7'h00;
   reg read_in = 1'b0;
   reg write_in = 1'b0;
   reg [31:0] writedata_in = 32'h0;
   reg blk_req = 1'b0;
   reg [15:0] ua = 16'h2710;
   reg [15:0] ub = 16'h2710;
   reg [15:0] uc = 16'h2710;
   wire [31:0] readdata_out;
   wire waitrequest_out, start_out, trip_out, blocked_out, irq_out, blk_line;
   wire [15:0] va, vb, vc;
   integer errors = 0, n_compared = 0, cycles = 0, t0, i;
   reg [31:0] rd;
   blocking_matrix_model u_bm (.clk_in(clk_in), .rst_in(rst_in), .block_req_in(blk_req),
      .va_req_in(ua), .vb_req_in(ub), .vc_req_in(uc), .block_out(blk_line),
      .volt_a_out(va), .volt_b_out(vb), .volt_c_out(vc));
   undervoltage_stage_blocking #(.CYCLE_CLKS(CYC)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
      .address_in(address_in), .read_in(read_in), .write_in(write_in),
      .writedata_in(writedata_in), .readdata_out(readdata_out),
      .waitrequest_out(waitrequest_out), .volt_a_in(va), .volt_b_in(vb), .volt_c_in(vc),
      .block_in(blk_line), .start_out(start_out), .trip_out(trip_out),
      .blocked_out(blocked_out), .irq_out(irq_out));
   always #4 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         errors = errors + 1;
         stop_test;
      end
   end
   task stop_test;
      begin
         $display("Counts: %0d compared, %0d errors", n_compared, errors);
         if (errors == 0 && n_compared > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task check(input [8*8-1:0] what, input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("Error %0s exp %h seen %h", what, exp, seen);
         end
      end
   endtask
   // Held until waitrequest low is sampled; value tested just after edges
   task bus(input w, input [6:0] a, input [31:0] d);
      begin
         @(posedge clk_in);
         address_in <= a;
         writedata_in <= d;
         write_in <= w;
         read_in <= !w;
         #1;
         while (waitrequest_out !== 1'b0) begin
            @(posedge clk_in);
            #1;
         end
         @(posedge clk_in);
         rd = readdata_out;
         write_in <= 1'b0;
         read_in <= 1'b0;
      end
   endtask
   task setv(input [15:0] a, input [15:0] b, input [15:0] c, input bk);
      begin
         @(posedge clk_in);
         ua <= a;
         ub <= b;
         uc <= c;
         blk_req <= bk;
      end
   endtask
   task steps(input integer n);
      begin
         repeat (n * CYC) @(posedge clk_in);
         #1;
      end
   endtask
   task wait_start;
      begin
         t0 = 0;
         while (start_out !== 1'b1 && t0 < 10 * CYC) begin
            @(posedge clk_in);
            #1;
            t0 = t0 + 1;
         end
         check("start", start_out, 1'b1);
      end
   endtask
   task t_regs;
      begin
         bus(0, `OFS_CTRL, 0); check("ctrl", rd, 32'h10);
         bus(0, `OFS_PICKUP, 0); check("pickup", rd, 32'h1770);
         bus(0, `OFS_BLOCKLVL, 0); check("blklvl", rd, 32'h3E8);
         bus(0, `OFS_DELAY, 0); check("delay", rd, 32'h14);
         bus(0, `OFS_VTSCALE, 0); check("vtscale", rd, 32'h186A0);
         bus(1, `OFS_STATUS, 32'hFFFF);
         bus(0, `OFS_STATUS, 0); check("status", rd, 32'h0);
         bus(0, 7'h44, 0); check("unmapped", rd, 32'h0);
         $display("t_regs done");
      end
   endtask
   task t_modes;
      begin
         for (i = 0; i < 6; i = i + 1) begin
            bus(1, `OFS_CTRL, 32'h10 | i);
            steps(2);
            bus(0, `OFS_STATUS, 0);
            check("behave", rd[10:8], (i > 4) ? 4 : i);
         end
         bus(0, `OFS_CTRL, 0); check("ctrl", rd, 32'h14);
         bus(1, `OFS_CTRL, 32'h10);
         $display("t_modes done");
      end
   endtask
   task t_dt;
      begin
         bus(1, `OFS_DELAY, 3);
         bus(1, `OFS_IRQ_MASK, 1);
         setv(16'h2710, 16'h1388, 16'h1D4C, 0);
         wait_start;
         t0 = cycles;
         bus(0, `OFS_EXPECTED, 0); check("expect", rd, 3);
         bus(0, `OFS_REMAIN, 0); check("remain", rd, 3);
         check("irq", irq_out, 1'b1);
         // Settled value after each edge, so the count ends on the trip edge
         while (trip_out !== 1'b1 && cycles - t0 < 10 * CYC) begin
            @(posedge clk_in);
            #1;
         end
         check("tripdly", cycles - t0, 3 * CYC);
         bus(0, `OFS_REMAIN, 0); check("remain0", rd, 0);
         bus(0, `OFS_RATIO_A, 0); check("ratio_a", rd, 10000 * 100 / 6000);
         bus(0, `OFS_RATIO_B, 0); check("ratio_b", rd, 5000 * 100 / 6000);
         bus(0, `OFS_RATIO_C, 0); check("ratio_c", rd, 7500 * 100 / 6000);
         bus(0, `OFS_RATIO_MIN, 0); check("ratio_mn", rd, 5000 * 100 / 6000);
         bus(0, `OFS_PICKUP_PRI, 0); check("pu_pri", rd, 6000 * 100000 / 10000);
         bus(0, `OFS_BLOCK_PRI, 0); check("bl_pri", rd, 1000 * 100000 / 10000);
         bus(1, `OFS_IRQ_STATUS, 32'hF);
         @(posedge clk_in);
         #1;
         check("irqclr", irq_out, 1'b0);
         bus(1, `OFS_IRQ_MASK, 0);
         // Just under the 103 percent release point
         setv(16'h2710, 16'h1823, 16'h2710, 0);
         steps(3);
         check("hold", start_out, 1'b1);
         setv(16'h2710, 16'h1824, 16'h2710, 0);
         steps(3);
         check("release", start_out, 1'b0);
         $display("t_dt done");
      end
   endtask
   task t_block;
      begin
         setv(16'h2710, 16'h2710, 16'h2710, 1);
         steps(2);
         setv(16'h1388, 16'h2710, 16'h2710, 1);
         steps(3);
         check("blocked", blocked_out, 1'b1);
         check("nostart", start_out, 1'b0);
         bus(0, `OFS_STATUS, 0); check("sampled", rd[5], 1'b1);
         setv(16'h2710, 16'h2710, 16'h2710, 0);
         steps(3);
         setv(16'h1388, 16'h2710, 16'h2710, 0);
         wait_start;
         // Short pulse between ticks must go unseen
         setv(16'h1388, 16'h2710, 16'h2710, 1);
         setv(16'h1388, 16'h2710, 16'h2710, 0);
         steps(1);
         check("pulse", start_out, 1'b1);
         // Block leads the trip by more than one program cycle
         setv(16'h1388, 16'h2710, 16'h2710, 1);
         steps(3);
         check("drop", start_out, 1'b0);
         check("notrip", trip_out, 1'b0);
         check("blk2", blocked_out, 1'b1);
         bus(0, `OFS_STATUS, 0); check("relbit", rd[6], 1'b1);
         setv(16'h2710, 16'h2710, 16'h2710, 0);
         steps(3);
         $display("t_block done");
      end
   endtask
   task t_deen;
      begin
         setv(16'h01F4, 16'h01F4, 16'h01F4, 0);
         steps(6);
         check("deen", trip_out, 1'b0);
         bus(0, `OFS_STATUS, 0); check("deenbit", rd[3], 1'b1);
         setv(16'h0BB8, 16'h0BB8, 16'h0BB8, 0);
         steps(6);
         check("deen2", trip_out, 1'b0);
         bus(0, `OFS_STATUS, 0); check("deenbit2", rd[3], 1'b1);
         setv(16'h17D4, 16'h17D4, 16'h17D4, 0);
         steps(3);
         bus(0, `OFS_STATUS, 0); check("deenoff", rd[3], 1'b0);
         setv(16'h2710, 16'h2710, 16'h2710, 0);
         steps(3);
         bus(1, `OFS_BLOCKLVL, 0);
         setv(16'h01F4, 16'h01F4, 16'h01F4, 0);
         steps(6);
         check("noblk", trip_out, 1'b1);
         setv(16'h2710, 16'h2710, 16'h2710, 0);
         steps(3);
         $display("t_deen done");
      end
   endtask
   // Inverse time with k = 3: t = 3 * 6000 / (6000 - umin)
   task t_curve;
      begin
         bus(1, `OFS_CTRL, 32'h20);
         setv(16'h0BB8, 16'h2710, 16'h2710, 0);
         steps(2);
         bus(0, `OFS_EXPECTED, 0); check("idmt1", rd, 6);
         setv(16'h1194, 16'h2710, 16'h2710, 0);
         steps(2);
         bus(0, `OFS_EXPECTED, 0); check("idmt2", rd, 12);
         check("idmttrip", trip_out, 1'b0);
         setv(16'h2710, 16'h2710, 16'h2710, 0);
         steps(3);
         bus(1, `OFS_CTRL, 32'h00);
         setv(16'h0BB8, 16'h2710, 16'h2710, 0);
         wait_start;
         check("instant", trip_out, 1'b1);
         bus(0, `OFS_EXPECTED, 0); check("inst_exp", rd, 0);
         $display("t_curve done");
      end
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      t_regs;
      t_modes;
      t_dt;
      t_block;
      t_deen;
      t_curve;
      stop_test;
   end
endmodule // undervoltage_stage_blocking_tb
`default_nettype wire
